// *** hw/cfcr_pkg.sv ***
package cfcr_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] LOW_CHANNEL_CONFIG_ADDR = 8'h05;
   localparam logic [7:0] SYSTEM_CONFIG_ADDR      = 8'h06;
   localparam logic [7:0] LOW_CHANNEL_CONFIG_RST  = 8'h01;
   localparam logic [7:0] SYSTEM_CONFIG_RST       = 8'h00;
   // ****************************************
   // low_channel_config fields
   // ****************************************
   localparam int FT_LSB             = 0;
   localparam int FT_W               = 5;
   localparam int LOW_MASTER_EN_BIT  = 5;
   localparam int LOW_START_GATE_BIT = 6;
   localparam int LOW_BLEED_BIT      = 7;
   // ****************************************
   // system_config fields
   // ****************************************
   localparam int PULLDOWN_TEST_BIT = 0;
   localparam int RETRY_SEL_BIT     = 1;
   localparam int POLARITY_BIT      = 2;
   localparam int REV_BLOCK_BIT     = 3;
   localparam int INRUSH_OVR_BIT    = 4;
   localparam int MANDATORY_BIT     = 5;
   localparam int CROSS_DIS_BIT     = 7;
   localparam logic [7:0] SYSTEM_CONFIG_MASK = 8'hBF;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_HZ          = 25_000_000;
   localparam int FT_STEP_NS      = 450_000;
   localparam int FT_STEP_CYCLES  = FT_STEP_NS / (1_000_000_000 / CLK_HZ);
   localparam int RETRY_FACTOR    = 100;
   localparam int TURNOFF_BURST_NS = 15_000;
   localparam int BURST_CYCLES    = TURNOFF_BURST_NS / (1_000_000_000 / CLK_HZ);
   localparam logic [3:0] CL_ALL_ONES = 4'hF;
endpackage : cfcr_pkg

// *** hw/cfcr_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module cfcr_top
   import cfcr_pkg::*;
#(
   parameter int STEP_CYCLES   = FT_STEP_CYCLES,
   parameter int BURST_CYC     = BURST_CYCLES
) (
   input  wire logic       clk,                 // 25 MHz clock
   input  wire logic       resetn,              // async reset, active low
   input  wire logic       reg_wr,              // register write strobe
   input  wire logic [7:0] reg_addr,            // register address
   input  wire logic [7:0] reg_wdata,           // write data
   output logic      [7:0] reg_rdata,           // read data
   input  wire logic       low_enable_pin,      // external enable pin
   input  wire logic       low_output_below,    // output under bleed threshold
   input  wire logic       low_reverse,         // output above input
   input  wire logic       low_in_limit,        // low channel in current limit
   input  wire logic       high_in_limit,       // high channel in current limit
   input  wire logic       high_master_enable,  // high channel enable bit
   input  wire logic [3:0] high_current_limit_field, // programmed high limit
   output logic            low_gate_on,         // low pass gate drive
   output logic            low_bleed_connect,   // bleed resistor switch
   output logic            low_oring_force,     // ORing paths act as input high
   output logic            high_gate_on,        // high gate pins released
   output logic            high_block_gate,     // high blocking gate released
   output logic            fast_turnoff,        // fast turnoff drivers on
   output logic      [3:0] high_limit_eff,      // effective high limit
   output logic            low_fault,           // low fault timer expired
   output logic            high_fault           // high fault timer expired
);
   // ****************************************
   // pin synchronisers
   // ****************************************
   logic [4:0] sync1_q, sync2_q;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {low_enable_pin, low_output_below, low_reverse, low_in_limit, high_in_limit};
         sync2_q <= sync1_q;
      end
   end
   wire logic en_pin  = sync2_q[4];
   wire logic out_low = sync2_q[3];
   wire logic rev     = sync2_q[2];
   wire logic low_cl  = sync2_q[1];
   wire logic high_cl = sync2_q[0];

   // ****************************************
   // registers
   // ****************************************
   logic [7:0] low_cfg_q, low_cfg_d, sys_cfg_q, sys_cfg_d;
   always_comb begin
      low_cfg_d = low_cfg_q;
      sys_cfg_d = sys_cfg_q;
      if (reg_wr && reg_addr == LOW_CHANNEL_CONFIG_ADDR) low_cfg_d = reg_wdata;
      if (reg_wr && reg_addr == SYSTEM_CONFIG_ADDR) sys_cfg_d = reg_wdata & SYSTEM_CONFIG_MASK;
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_cfg_q <= LOW_CHANNEL_CONFIG_RST;
         sys_cfg_q <= SYSTEM_CONFIG_RST;
      end else begin
         low_cfg_q <= low_cfg_d;
         sys_cfg_q <= sys_cfg_d;
      end
   end
   wire logic [4:0] ft_code   = low_cfg_q[FT_LSB +: FT_W];
   wire logic       low_men   = low_cfg_q[LOW_MASTER_EN_BIT];
   wire logic       start_g   = low_cfg_q[LOW_START_GATE_BIT];
   wire logic       pd_test   = sys_cfg_q[PULLDOWN_TEST_BIT];
   wire logic       retry     = sys_cfg_q[RETRY_SEL_BIT];
   wire logic       rev_en    = sys_cfg_q[REV_BLOCK_BIT];
   wire logic       inrush    = sys_cfg_q[INRUSH_OVR_BIT];
   wire logic       cross_dis = sys_cfg_q[CROSS_DIS_BIT];

   // fault time in cycles; the same programmed time serves both channels
   function automatic logic [31:0] ft_cycles(input logic [4:0] code, input int mult);
      ft_cycles = 32'(code) * 32'(STEP_CYCLES) * 32'(mult);
   endfunction : ft_cycles

   // ****************************************
   // channel state machines
   // ****************************************
   typedef enum logic [1:0] {CFCR_OFF, CFCR_ON, CFCR_LATCHED, CFCR_WAIT} cfcr_state_t;
   cfcr_state_t low_st_q, low_st_d, hi_st_q, hi_st_d;
   logic [31:0] low_cnt_q, low_cnt_d, hi_cnt_q, hi_cnt_d, burst_q, burst_d;
   logic        hi_en_q, cross_off_q, cross_off_d, inrush_q, inrush_d;
   logic        low_run, low_exp, hi_exp, hi_run;

   always_comb begin
      low_st_d    = low_st_q;
      low_cnt_d   = low_cnt_q;
      hi_st_d     = hi_st_q;
      hi_cnt_d    = hi_cnt_q;
      cross_off_d = cross_off_q;
      inrush_d    = inrush_q;
      // enable toggle re-arms the high channel; a same-cycle low fault wins below
      if (!high_master_enable && hi_en_q) cross_off_d = 1'b0;
      low_run     = low_men && en_pin && !(rev_en && rev);
      low_exp     = 1'b0;
      hi_exp      = 1'b0;
      hi_run      = high_master_enable && !pd_test && !cross_off_q;
      unique case (low_st_q)
         CFCR_OFF: begin
            low_cnt_d = 32'h0;
            if (low_run && (!start_g || out_low)) low_st_d = CFCR_ON;
         end
         CFCR_ON: begin
            if (!low_run) low_st_d = CFCR_OFF;
            else if (low_cl) begin
               low_cnt_d = low_cnt_q + 32'h1;
               if (low_cnt_q + 32'h1 >= ft_cycles(ft_code, 1)) begin
                  low_exp   = 1'b1;
                  low_cnt_d = 32'h0;
                  low_st_d  = retry ? CFCR_WAIT : CFCR_LATCHED;
                  if (!cross_dis) cross_off_d = 1'b1;
               end
            end else low_cnt_d = 32'h0;
         end
         CFCR_LATCHED: if (!low_men) low_st_d = CFCR_OFF;
         CFCR_WAIT: begin
            low_cnt_d = low_cnt_q + 32'h1;
            if (low_cnt_q + 32'h1 >= ft_cycles(ft_code, RETRY_FACTOR))
               low_st_d = CFCR_OFF;
         end
      endcase
      unique case (hi_st_q)
         CFCR_OFF: begin
            hi_cnt_d = 32'h0;
            if (hi_run) begin
               hi_st_d  = CFCR_ON;
               inrush_d = inrush;
            end
         end
         CFCR_ON: begin
            if (!hi_run) begin
               hi_st_d  = CFCR_OFF;
               inrush_d = 1'b0;
            end else if (high_cl) begin
               hi_cnt_d = hi_cnt_q + 32'h1;
               if (hi_cnt_q + 32'h1 >= ft_cycles(ft_code, 1)) begin
                  hi_exp   = 1'b1;
                  hi_cnt_d = 32'h0;
                  inrush_d = 1'b0;
                  hi_st_d  = retry ? CFCR_WAIT : CFCR_LATCHED;
               end
            end else begin
               hi_cnt_d = 32'h0;
               if (hi_cnt_q != 32'h0) inrush_d = 1'b0;
            end
         end
         CFCR_LATCHED: if (!high_master_enable) hi_st_d = CFCR_OFF;
         CFCR_WAIT: begin
            hi_cnt_d = hi_cnt_q + 32'h1;
            if (hi_cnt_q + 32'h1 >= ft_cycles(ft_code, RETRY_FACTOR)) hi_st_d = CFCR_OFF;
         end
      endcase
   end

   always_comb begin
      burst_d = burst_q;
      if ((low_exp || hi_exp) && burst_q == 32'h0) burst_d = 32'(BURST_CYC);
      else if (burst_q != 32'h0) burst_d = burst_q - 32'h1;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         low_st_q    <= CFCR_OFF;
         hi_st_q     <= CFCR_OFF;
         low_cnt_q   <= 32'h0;
         hi_cnt_q    <= 32'h0;
         burst_q     <= 32'h0;
         hi_en_q     <= 1'b0;
         cross_off_q <= 1'b0;
         inrush_q    <= 1'b0;
      end else begin
         low_st_q    <= low_st_d;
         hi_st_q     <= hi_st_d;
         low_cnt_q   <= low_cnt_d;
         hi_cnt_q    <= hi_cnt_d;
         burst_q     <= burst_d;
         hi_en_q     <= high_master_enable;
         cross_off_q <= cross_off_d;
         inrush_q    <= inrush_d;
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata         <= 8'h00;
         low_gate_on       <= 1'b0;
         low_bleed_connect <= 1'b0;
         low_oring_force   <= 1'b0;
         high_gate_on      <= 1'b0;
         high_block_gate   <= 1'b0;
         fast_turnoff      <= 1'b0;
         high_limit_eff    <= 4'h0;
         low_fault         <= 1'b0;
         high_fault        <= 1'b0;
      end else begin
         reg_rdata <= (reg_addr == LOW_CHANNEL_CONFIG_ADDR) ? low_cfg_q :
                      (reg_addr == SYSTEM_CONFIG_ADDR) ? sys_cfg_q : 8'h00;
         low_gate_on       <= (low_st_d == CFCR_ON);
         low_bleed_connect <= low_cfg_d[LOW_BLEED_BIT];
         low_oring_force   <= !sys_cfg_d[REV_BLOCK_BIT];
         high_gate_on      <= (hi_st_d == CFCR_ON);
         high_block_gate   <= (hi_st_d == CFCR_ON);
         fast_turnoff      <= pd_test || burst_d != 32'h0;
         high_limit_eff    <= inrush_d ? CL_ALL_ONES : high_current_limit_field;
         low_fault         <= low_exp;
         high_fault        <= hi_exp;
      end
   end
endmodule : cfcr_top
`default_nettype wire

// *** verif/cfcr_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// checker
// ****************************************
module cfcr_properties
   import cfcr_pkg::*;
(
   input wire logic       clk,                      // clock
   input wire logic       resetn,                   // reset
   input wire logic       reg_wr,                   // strobe
   input wire logic [7:0] reg_addr,                 // address
   input wire logic [7:0] reg_wdata,                // data
   input wire logic       low_enable_pin,           // pin
   input wire logic       high_master_enable,       // enable
   input wire logic [3:0] high_current_limit_field, // limit
   input wire logic       low_gate_on,              // gate
   input wire logic       low_bleed_connect,        // bleed
   input wire logic       low_oring_force,          // oring
   input wire logic       high_gate_on,             // gate
   input wire logic       high_block_gate,          // block
   input wire logic       fast_turnoff,             // drivers
   input wire logic [3:0] high_limit_eff,           // limit
   input wire logic       low_fault                 // fault
);
   logic [7:0] lo_q;
   logic [7:0] sy_q;
   logic [1:0] up_q;
   wire logic  wl = reg_wr && reg_addr == LOW_CHANNEL_CONFIG_ADDR;
   wire logic  ws = reg_wr && reg_addr == SYSTEM_CONFIG_ADDR;
   // shadow of the written configuration
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lo_q <= LOW_CHANNEL_CONFIG_RST;
         sy_q <= 8'h00;
         up_q <= 2'h0;
      end else begin
         if (wl) lo_q <= reg_wdata;
         if (ws) sy_q <= reg_wdata & SYSTEM_CONFIG_MASK;
         if (up_q != 2'h3) up_q <= up_q + 2'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_fault; low_fault ##0 !sy_q[RETRY_SEL_BIT]; endsequence
   sequence s_off8; !low_gate_on [*8]; endsequence
   a_bleed_follows: assert property (
      (up_q == 2'h3 && !wl) [*2] |-> low_bleed_connect == lo_q[7])
      else $error("bleed switch differs from config");
   a_oring_force: assert property (
      (up_q == 2'h3 && !ws) [*2] |-> low_oring_force == !sy_q[3])
      else $error("oring force differs from config");
   a_gate_needs_bit: assert property (!lo_q[LOW_MASTER_EN_BIT] [*2] |-> !low_gate_on)
      else $error("low gate on with enable bit clear");
   a_gate_needs_pin: assert property (!low_enable_pin [*4] |-> !low_gate_on)
      else $error("low gate on with pin low");
   a_high_enable_off: assert property (
      !high_master_enable [*2] |-> !high_gate_on && !high_block_gate)
      else $error("high gates on with enable clear");
   a_pulldown_forces: assert property (
      sy_q[PULLDOWN_TEST_BIT] [*2] |-> fast_turnoff && !high_gate_on && !high_block_gate)
      else $error("pulldown test not forcing gates");
   a_burst_after_fault: assert property (low_fault |-> fast_turnoff [*8])
      else $error("turnoff burst too short after fault");
   a_fault_shuts_low: assert property (low_fault |-> ##[0:2] !low_gate_on)
      else $error("low gate on after fault");
   a_cross_shuts_high: assert property (
      low_fault && !sy_q[CROSS_DIS_BIT] |-> ##[0:2] !high_gate_on)
      else $error("high gate on after low fault");
   a_latch_off_hold: assert property (s_fault |-> ##2 s_off8)
      else $error("low channel restarted in latch mode");
   a_limit_pass: assert property (
      (up_q == 2'h3 && !sy_q[INRUSH_OVR_BIT] && $stable(high_current_limit_field)) [*3]
      |-> high_limit_eff == high_current_limit_field)
      else $error("effective limit differs from field");
endmodule : cfcr_properties
bind cfcr_top cfcr_properties chk_u (.clk, .resetn, .reg_wr, .reg_addr, .reg_wdata,
   .low_enable_pin, .high_master_enable, .high_current_limit_field, .low_gate_on, .low_bleed_connect,
   .low_oring_force, .high_gate_on, .high_block_gate, .fast_turnoff, .high_limit_eff, .low_fault);
`default_nettype wire

// *** verif/cfcr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// management host
// ****************************************
module cfcr_host
   import cfcr_pkg::*;
(
   input  wire logic       clk,       // clock
   input  wire logic [7:0] reg_rdata, // read data
   output logic            reg_wr,    // strobe
   output logic      [7:0] reg_addr,  // address
   output logic      [7:0] reg_wdata  // data
);
   initial begin
      reg_wr = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr
   task sys(input logic [7:0] d);
      wr(SYSTEM_CONFIG_ADDR, (d & 8'hFB) | 8'h20);
   endtask : sys
   // b holds bleed, start gate, enable
   task low(input logic [4:0] ft, input logic [2:0] b);
      wr(LOW_CHANNEL_CONFIG_ADDR, {b, (ft == 5'h00) ? 5'h01 : ft});
   endtask : low
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      // take the data in the settled half of the cycle
      @(negedge clk);
      d = reg_rdata;
   endtask : rd
endmodule : cfcr_host
`default_nettype wire

// *** verif/cfcr_top_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// testbench
// ****************************************
module cfcr_top_tb
   import cfcr_pkg::*;
;
   logic       clk = 1'h0, resetn = 1'h0, reg_wr, pin, below, rev;
   logic       lil, hil, hme, lgo, lbc, lof, hgo, hbg, fto, lft, hft;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv;
   logic [3:0] hcl, hle;
   int         err_count = 0, compares = 0, n;
   always #20 clk = ~clk;
   cfcr_top #(.STEP_CYCLES(4), .BURST_CYC(8)) dut_u (.clk, .resetn, .reg_wr, .reg_addr,
      .reg_wdata, .reg_rdata, .low_enable_pin(pin), .low_output_below(below), .low_reverse(rev),
      .low_in_limit(lil), .high_in_limit(hil), .high_master_enable(hme),
      .high_current_limit_field(hcl), .low_gate_on(lgo), .low_bleed_connect(lbc),
      .low_oring_force(lof), .high_gate_on(hgo), .high_block_gate(hbg), .fast_turnoff(fto),
      .high_limit_eff(hle), .low_fault(lft), .high_fault(hft));
   cfcr_host host_u (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
   task chk(input string s, input logic [7:0] v, input logic [7:0] e);
      compares++;
      if (v !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", s, e, v);
      end
   endtask : chk
   task finish_test;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   // bounded wait, n holds the cycles taken
   task automatic wt(ref logic s, input logic v, input int b);
      for (n = 0; n < b && s !== v; n++) @(negedge clk);
      if (n >= b) begin
         err_count++;
         finish_test;
      end
   endtask : wt
   initial begin
      pin   <= 1'h0;
      below <= 1'h0;
      rev   <= 1'h0;
      lil   <= 1'h0;
      hil   <= 1'h0;
      hme   <= 1'h0;
      hcl   <= 4'h3;
      repeat (10) @(posedge clk);
      resetn <= 1'h1;
      host_u.rd(LOW_CHANNEL_CONFIG_ADDR, rdv);
      chk("low cfg", rdv, 8'h01);
      host_u.rd(SYSTEM_CONFIG_ADDR, rdv);
      chk("sys cfg", rdv, 8'h00);
      chk("oring", 8'(lof), 8'h01);
      host_u.sys(8'hFF);
      host_u.rd(SYSTEM_CONFIG_ADDR, rdv);
      chk("sys cfg", rdv, 8'hBB);
      chk("turnoff", 8'(fto), 8'h01);
      host_u.wr(8'h09, 8'h55);
      host_u.rd(8'h09, rdv);
      chk("unmapped", rdv, 8'h00);
      host_u.sys(8'h00);
      wt(fto, 1'h0, 20);
      @(posedge clk);
      pin <= 1'h1;
      below <= 1'h1;
      hme <= 1'h1;
      host_u.low(5'h03, 3'h5);
      wt(lgo, 1'h1, 20);
      chk("bleed", 8'(lbc), 8'h01);
      wt(hgo, 1'h1, 20);
      @(posedge clk);
      lil <= 1'h1;
      wt(lft, 1'h1, 100);
      chk("fault time", 8'(n >= 12 && n <= 16), 8'h01);
      chk("burst", 8'(fto), 8'h01);
      @(posedge clk);
      lil <= 1'h0;
      repeat (40) @(negedge clk);
      chk("latched", 8'(lgo), 8'h00);
      chk("cross", 8'(hgo), 8'h00);
      chk("burst end", 8'(fto), 8'h00);
      @(posedge clk);
      hme <= 1'h0;
      host_u.low(5'h03, 3'h4);
      host_u.sys(8'h02);
      host_u.low(5'h03, 3'h5);
      hme <= 1'h1;
      wt(hgo, 1'h1, 20);
      @(posedge clk);
      lil <= 1'h1;
      wt(lft, 1'h1, 100);
      @(posedge clk);
      lil <= 1'h0;
      wt(lgo, 1'h1, 1300);
      chk("retry wait", 8'(n >= 1195 && n <= 1215), 8'h01);
      chk("high off", 8'(hgo), 8'h00);
      @(posedge clk);
      hme <= 1'h0;
      repeat (3) @(posedge clk);
      hme <= 1'h1;
      wt(hgo, 1'h1, 20);
      host_u.sys(8'h12);
      hme <= 1'h0;
      repeat (3) @(posedge clk);
      hme <= 1'h1;
      hil <= 1'h1;
      repeat (4) @(negedge clk);
      chk("inrush", 8'(hle), 8'h0F);
      @(posedge clk);
      hil <= 1'h0;
      repeat (5) @(negedge clk);
      chk("limit", 8'(hle), 8'h03);
      @(posedge clk);
      hcl <= 4'h9;
      repeat (2) @(negedge clk);
      chk("limit", 8'(hle), 8'h09);
      @(posedge clk);
      hil <= 1'h1;
      wt(hft, 1'h1, 100);
      chk("high fault time", 8'(n >= 12 && n <= 16), 8'h01);
      repeat (2) @(negedge clk);
      chk("high off", 8'(hgo), 8'h00);
      chk("block off", 8'(hbg), 8'h00);
      @(posedge clk);
      hil <= 1'h0;
      @(posedge clk);
      below <= 1'h0;
      host_u.low(5'h01, 3'h0);
      wt(lgo, 1'h0, 10);
      host_u.low(5'h01, 3'h3);
      repeat (10) @(negedge clk);
      chk("start gate", 8'(lgo), 8'h00);
      chk("bleed", 8'(lbc), 8'h00);
      @(posedge clk);
      below <= 1'h1;
      wt(lgo, 1'h1, 20);
      host_u.sys(8'h08);
      rev <= 1'h1;
      wt(lgo, 1'h0, 10);
      chk("oring", 8'(lof), 8'h00);
      @(posedge clk);
      rev <= 1'h0;
      wt(lgo, 1'h1, 20);
      @(posedge clk);
      pin <= 1'h0;
      wt(lgo, 1'h0, 10);
      finish_test;
   end
endmodule : cfcr_top_tb
`default_nettype wire
